// *** hdl/frlac_pkg.sv ***
// constants for the framer loopback, reset and remote alarm control block
package frlac_pkg;

	// ==========================================================
	// framers and register map
	localparam int          NUM_FRAMERS = 2;
	localparam int          ADDR_W      = 12;
	localparam int          DATA_W      = 8;
	localparam logic [11:0] SEC_LOOP_OFS_A = 12'h0679;
	localparam logic [11:0] RST_TRN_OFS_A  = 12'h067a;
	localparam logic [11:0] ALARM_OFS_A    = 12'h067b;
	localparam logic [11:0] STATUS_OFS_A   = 12'h06fe;
	localparam logic [11:0] SEC_LOOP_OFS_B = 12'h0c79;
	localparam logic [11:0] RST_TRN_OFS_B  = 12'h0c7a;
	localparam logic [11:0] ALARM_OFS_B    = 12'h0c7b;
	localparam logic [11:0] STATUS_OFS_B   = 12'h0cfe;

	// ==========================================================
	// reset values
	localparam logic [7:0] SEC_LOOP_RST = 8'h00;
	localparam logic [7:0] RST_TRN_RST  = 8'h00;
	localparam logic [7:0] ALARM_RST    = 8'h00;

	// ==========================================================
	// secondary loopback register fields
	localparam int SLOT_LSB   = 0;
	localparam int SLOT_W     = 5;
	localparam int LCODE_LSB  = 5;
	localparam int LCODE_W    = 2;
	localparam int SEC_RSV_BIT = 7;

	// ==========================================================
	// reset and transparent register fields
	localparam int SOFT_RESET_BIT   = 0;
	localparam int SOFT_RESTART_BIT = 1;
	localparam int REALIGN_BIT      = 2;
	localparam int TRANSP_BOTH_BIT  = 3;
	localparam int TRANSP_TX_BIT    = 4;
	localparam int SYNC_MASK_BIT    = 5;
	localparam logic [7:0] RST_TRN_WMASK = 8'h3e;

	// ==========================================================
	// remote alarm register fields
	localparam int AUTO_RFA_BIT    = 0;
	localparam int AUTO_SIG_BIT    = 1;
	localparam int AUTO_CRC_BIT    = 2;
	localparam int AUTO_TMR_BIT    = 3;
	localparam int AUTO_PAT8_BIT   = 4;
	localparam int AUTO_PATC_BIT   = 5;
	localparam int SEND_JAPAN_BIT  = 6;
	localparam int SEND_RFA_BIT    = 7;

	// ==========================================================
	// loop codes
	typedef enum logic [1:0] {
		FRLAC_SEC_NONE = 2'h0,
		FRLAC_SEC_SYS  = 2'h1,
		FRLAC_SEC_LINE = 2'h2,
		FRLAC_SEC_RSV  = 2'h3
	} frlac_sec_code_t;

	localparam logic [2:0] PRI_LINE_LOOP    = 3'h1;
	localparam logic [2:0] PRI_BOARD_LOOP   = 3'h2;
	localparam logic [2:0] PRI_PAYLOAD_REGEN = 3'h6;
	localparam logic [2:0] PRI_PAYLOAD_PASS = 3'h7;

	// ==========================================================
	// timing, in receive line clock cycles
	localparam int SOFT_RESET_LINE_CYCLES = 4;

endpackage : frlac_pkg

// *** hdl/frlac_reset_seq.sv ***
// per-framer soft reset sequencer and realign edge detector
`timescale 1ns/1ps
`default_nettype none

module frlac_reset_seq #(
	parameter int HOLD_CYCLES = frlac_pkg::SOFT_RESET_LINE_CYCLES
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// line clock enable
	input  wire logic line_clk_en,
	// commands from the register file
	input  wire logic soft_reset_start,
	input  wire logic restart_level,
	input  wire logic realign_level,
	// results
	output logic      soft_reset_busy,
	output logic      framer_rst,
	output logic      realign_pulse
);

	// ==========================================================
	// hold counter
	logic [3:0] cnt_q;
	logic       busy_q;
	logic       realign_prev_q;

	// counts line clock enables, not core cycles, so the hold scales with line rate
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			cnt_q  <= 4'h0;
		end else if (soft_reset_start) begin
			busy_q <= 1'b1;
			cnt_q  <= 4'(HOLD_CYCLES);
		end else if (busy_q && line_clk_en) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				busy_q <= 1'b0; // self-clear
			end
		end
	end

	// ==========================================================
	// realign rising edge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			realign_prev_q <= 1'b0;
			realign_pulse  <= 1'b0;
		end else begin
			realign_prev_q <= realign_level;
			realign_pulse  <= realign_level & ~realign_prev_q;
		end
	end

	// restart holds reset for as long as the level stays set
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			framer_rst <= 1'b1;
		end else begin
			framer_rst <= soft_reset_start | busy_q | restart_level;
		end
	end

	assign soft_reset_busy = busy_q;

endmodule : frlac_reset_seq

`default_nettype wire

// *** hdl/frlac_ctrl.sv ***
// register bank and control decode for framer loopback, reset and alarm
//
// Operation
// - secondary loop acts only if slot differs and no line, board, payload loop
// - secondary register bits 4:0 hold the looped time slot number
// - bits 6:5 decode none, system loop, line loop, reserved
// - secondary register resets to zero; bit 7 is written as zero
// - soft reset holds framer four line clocks, defaults registers, self-clears
// - restart bit holds framer reset while set; datalink parameters reset
// - rising edge of reframe bit forces alignment loss and new search
// - transparent mode 1 passes data both ways, no frame alignment
// - DS1 transparent transmit takes F bit from system slot 0 bit 7
// - DS1 mode 1 receive copies line F bit into system slot 0 bit 7
// - CEPT mode 1 passes slot 0 unchanged in both directions
// - transparent mode 2 makes only transmit transparent
// - sync mask makes transmit framer ignore system frame sync after the first pulse since framer reset
// - auto remote alarm while receive framer has alignment loss
// - CEPT auto A bit on signalling multiframe loss
// - CEPT auto A bit on slot 0 multiframe loss
// - CEPT auto A bit on multiframe reframe timer expiry
// - CEPT auto A bit on spare pattern 1000 or 1100
// - bit 6 sends the Japanese D4 remote alarm
// - bit 7 sends remote alarm for the selected format
// - board loopback loops system data back and sends AIS on line
`timescale 1ns/1ps
`default_nettype none

module frlac_ctrl #(
	parameter int NF = frlac_pkg::NUM_FRAMERS
) (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	// register port
	input  wire logic [11:0]            reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	// per-framer receive line clock enable
	input  wire logic [NF-1:0]          rx_framer_line_clock,
	// per-framer format and primary loopback state
	input  wire logic [NF-1:0]          cept_mode,
	input  wire logic [NF-1:0][2:0]     primary_loop_code,
	input  wire logic [NF-1:0][4:0]     primary_slot_number,
	// per-framer receive framer conditions
	input  wire logic [NF-1:0]          rx_align_loss_flag,
	input  wire logic [NF-1:0]          rx_sig_mf_loss_flag,
	input  wire logic [NF-1:0]          rx_crc_mf_loss_flag,
	input  wire logic [NF-1:0]          rx_mf_timer_expired,
	input  wire logic [NF-1:0]          rx_spare_pattern_8,
	input  wire logic [NF-1:0]          rx_spare_pattern_c,
	// per-framer system frame sync
	input  wire logic [NF-1:0]          sys_frame_sync,
	// framer reset and realign
	output logic      [NF-1:0]          framer_rst,
	output logic      [NF-1:0]          datalink_param_reset,
	output logic      [NF-1:0]          force_realign,
	// secondary loopback
	output logic      [NF-1:0]          sec_loop_sys,
	output logic      [NF-1:0]          sec_loop_line,
	output logic      [NF-1:0][4:0]     secondary_slot_number,
	// primary board loopback side effects
	output logic      [NF-1:0]          board_loop_active,
	output logic      [NF-1:0]          line_ais_send,
	// transparent framing
	output logic      [NF-1:0]          tx_transparent,
	output logic      [NF-1:0]          rx_transparent,
	output logic      [NF-1:0]          rx_align_inhibit,
	output logic      [NF-1:0]          tx_fbit_from_sys,
	output logic      [NF-1:0]          rx_fbit_to_sys,
	output logic      [NF-1:0]          tx_ts0_from_sys,
	output logic      [NF-1:0]          rx_ts0_to_sys,
	// gated transmit frame sync
	output logic      [NF-1:0]          tx_frame_sync,
	// alarms to the transmit framer
	output logic      [NF-1:0]          send_remote_alarm,
	output logic      [NF-1:0]          send_a_bit,
	output logic      [NF-1:0]          send_japan_alarm
);

	// ==========================================================
	// address decode
	typedef enum logic [2:0] {
		FRLAC_SEL_NONE,
		FRLAC_SEL_SEC,
		FRLAC_SEL_RST,
		FRLAC_SEL_ALARM,
		FRLAC_SEL_STATUS
	} frlac_sel_t;

	// used for both the write and the read paths
	function automatic frlac_sel_t dec_reg(input logic [11:0] a, input int f);
		frlac_sel_t s;
		s = FRLAC_SEL_NONE;
		if (f == 0) begin
			if (a == frlac_pkg::SEC_LOOP_OFS_A) s = FRLAC_SEL_SEC;
			if (a == frlac_pkg::RST_TRN_OFS_A) s = FRLAC_SEL_RST;
			if (a == frlac_pkg::ALARM_OFS_A) s = FRLAC_SEL_ALARM;
			if (a == frlac_pkg::STATUS_OFS_A) s = FRLAC_SEL_STATUS;
		end else begin
			if (a == frlac_pkg::SEC_LOOP_OFS_B) s = FRLAC_SEL_SEC;
			if (a == frlac_pkg::RST_TRN_OFS_B) s = FRLAC_SEL_RST;
			if (a == frlac_pkg::ALARM_OFS_B) s = FRLAC_SEL_ALARM;
			if (a == frlac_pkg::STATUS_OFS_B) s = FRLAC_SEL_STATUS;
		end
		return s;
	endfunction : dec_reg

	// ==========================================================
	// per-framer register state
	logic [NF-1:0][7:0] sec_q;
	logic [NF-1:0][7:0] rst_q;
	logic [NF-1:0][7:0] alarm_q;
	logic [NF-1:0]      soft_start;
	logic [NF-1:0]      soft_busy;
	logic [NF-1:0]      sync_seen_q;
	logic [NF-1:0][7:0] rd_val;

	genvar g;
	generate
		for (g = 0; g < NF; g++) begin : g_fr
			frlac_sel_t wsel;
			frlac_sel_t rsel;
			logic       pri_blocks;
			logic       slot_clash;
			logic       auto_a_any;
			logic       auto_rfa;
			logic [1:0] code;

			assign wsel = reg_wr ? dec_reg(reg_addr, g) : FRLAC_SEL_NONE;
			assign rsel = dec_reg(reg_addr, g);
			assign soft_start[g] = (wsel == FRLAC_SEL_RST)
				&& reg_wdata[frlac_pkg::SOFT_RESET_BIT] && !soft_busy[g];

			// soft reset wipes the registers and keeps them at defaults while held
			always_ff @(posedge core_clk) begin
				if (sys_rst || soft_start[g] || soft_busy[g]) begin
					sec_q[g]   <= frlac_pkg::SEC_LOOP_RST;
					rst_q[g]   <= frlac_pkg::RST_TRN_RST;
					alarm_q[g] <= frlac_pkg::ALARM_RST;
				end else begin
					if (wsel == FRLAC_SEL_SEC) begin
						// reserved top bit never stored
						sec_q[g] <= {1'b0, reg_wdata[6:0]};
					end
					if (wsel == FRLAC_SEL_RST) begin
						rst_q[g] <= reg_wdata & frlac_pkg::RST_TRN_WMASK;
					end
					if (wsel == FRLAC_SEL_ALARM) begin
						alarm_q[g] <= reg_wdata;
					end
				end
			end

			frlac_reset_seq #(
				.HOLD_CYCLES(frlac_pkg::SOFT_RESET_LINE_CYCLES)
			) u_seq (
				.core_clk        (core_clk),
				.sys_rst         (sys_rst),
				.line_clk_en     (rx_framer_line_clock[g]),
				.soft_reset_start(soft_start[g]),
				.restart_level   (rst_q[g][frlac_pkg::SOFT_RESTART_BIT]),
				.realign_level   (rst_q[g][frlac_pkg::REALIGN_BIT]),
				.soft_reset_busy (soft_busy[g]),
				.framer_rst      (framer_rst[g]),
				.realign_pulse   (force_realign[g])
			);

			// ==================================================
			// secondary loopback qualification
			assign code = sec_q[g][frlac_pkg::LCODE_LSB +: frlac_pkg::LCODE_W];
			assign pri_blocks = (primary_loop_code[g] == frlac_pkg::PRI_LINE_LOOP)
				|| (primary_loop_code[g] == frlac_pkg::PRI_BOARD_LOOP)
				|| (primary_loop_code[g] == frlac_pkg::PRI_PAYLOAD_REGEN)
				|| (primary_loop_code[g] == frlac_pkg::PRI_PAYLOAD_PASS);
			assign slot_clash = primary_slot_number[g]
				== sec_q[g][frlac_pkg::SLOT_LSB +: frlac_pkg::SLOT_W];

			// reserved code and blocked cases both fall to no loopback
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					sec_loop_sys[g]  <= 1'b0;
					sec_loop_line[g] <= 1'b0;
					secondary_slot_number[g] <= 5'h00;
				end else begin
					sec_loop_sys[g] <= !pri_blocks && !slot_clash
						&& (code == frlac_pkg::FRLAC_SEC_SYS);
					sec_loop_line[g] <= !pri_blocks && !slot_clash
						&& (code == frlac_pkg::FRLAC_SEC_LINE);
					secondary_slot_number[g] <=
						sec_q[g][frlac_pkg::SLOT_LSB +: frlac_pkg::SLOT_W];
				end
			end

			// board loopback returns system data and fills the line with AIS
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					board_loop_active[g] <= 1'b0;
					line_ais_send[g]     <= 1'b0;
				end else begin
					board_loop_active[g] <=
						primary_loop_code[g] == frlac_pkg::PRI_BOARD_LOOP;
					line_ais_send[g] <=
						primary_loop_code[g] == frlac_pkg::PRI_BOARD_LOOP;
				end
			end

			// ==================================================
			// restart also sends datalink parameters back to defaults
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					datalink_param_reset[g] <= 1'b1;
				end else begin
					datalink_param_reset[g] <= rst_q[g][frlac_pkg::SOFT_RESTART_BIT]
						| soft_busy[g];
				end
			end

			// ==================================================
			// transparent framing; datalink bit select is software's job
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					tx_transparent[g]   <= 1'b0;
					rx_transparent[g]   <= 1'b0;
					rx_align_inhibit[g] <= 1'b0;
					tx_fbit_from_sys[g] <= 1'b0;
					rx_fbit_to_sys[g]   <= 1'b0;
					tx_ts0_from_sys[g]  <= 1'b0;
					rx_ts0_to_sys[g]    <= 1'b0;
				end else begin
					tx_transparent[g] <= rst_q[g][frlac_pkg::TRANSP_BOTH_BIT]
						| rst_q[g][frlac_pkg::TRANSP_TX_BIT];
					rx_transparent[g] <= rst_q[g][frlac_pkg::TRANSP_BOTH_BIT];
					rx_align_inhibit[g] <= rst_q[g][frlac_pkg::TRANSP_BOTH_BIT];
					tx_fbit_from_sys[g] <= !cept_mode[g]
						&& (rst_q[g][frlac_pkg::TRANSP_BOTH_BIT]
						|| rst_q[g][frlac_pkg::TRANSP_TX_BIT]);
					rx_fbit_to_sys[g] <= !cept_mode[g]
						&& rst_q[g][frlac_pkg::TRANSP_BOTH_BIT];
					tx_ts0_from_sys[g] <= cept_mode[g]
						&& (rst_q[g][frlac_pkg::TRANSP_BOTH_BIT]
						|| rst_q[g][frlac_pkg::TRANSP_TX_BIT]);
					rx_ts0_to_sys[g] <= cept_mode[g]
						&& rst_q[g][frlac_pkg::TRANSP_BOTH_BIT];
				end
			end

			// ==================================================
			// sync mask only bites once a pulse has set the counts up
			always_ff @(posedge core_clk) begin
				if (sys_rst || framer_rst[g]) begin
					sync_seen_q[g] <= 1'b0;
				end else if (sys_frame_sync[g]) begin
					sync_seen_q[g] <= 1'b1;
				end
			end

			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					tx_frame_sync[g] <= 1'b0;
				end else begin
					tx_frame_sync[g] <= sys_frame_sync[g]
						&& !(rst_q[g][frlac_pkg::SYNC_MASK_BIT]
						&& sync_seen_q[g]);
				end
			end

			// ==================================================
			// remote alarm and A bit
			assign auto_rfa = alarm_q[g][frlac_pkg::AUTO_RFA_BIT]
				&& rx_align_loss_flag[g];
			assign auto_a_any = cept_mode[g] && (
				(alarm_q[g][frlac_pkg::AUTO_SIG_BIT] && rx_sig_mf_loss_flag[g])
				|| (alarm_q[g][frlac_pkg::AUTO_CRC_BIT] && rx_crc_mf_loss_flag[g])
				|| (alarm_q[g][frlac_pkg::AUTO_TMR_BIT] && rx_mf_timer_expired[g])
				|| (alarm_q[g][frlac_pkg::AUTO_PAT8_BIT] && rx_spare_pattern_8[g])
				|| (alarm_q[g][frlac_pkg::AUTO_PATC_BIT] && rx_spare_pattern_c[g]));

			// level follows the causes, so it drops as soon as all clear
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					send_remote_alarm[g] <= 1'b0;
					send_a_bit[g]        <= 1'b0;
					send_japan_alarm[g]  <= 1'b0;
				end else begin
					send_remote_alarm[g] <= auto_rfa || auto_a_any
						|| alarm_q[g][frlac_pkg::SEND_RFA_BIT];
					send_a_bit[g] <= cept_mode[g] && (auto_rfa || auto_a_any
						|| alarm_q[g][frlac_pkg::SEND_RFA_BIT]);
					send_japan_alarm[g] <=
						alarm_q[g][frlac_pkg::SEND_JAPAN_BIT];
				end
			end

			// ==================================================
			// read value; soft reset bit reads as busy until it self-clears
			always_comb begin
				unique case (rsel)
					FRLAC_SEL_SEC: rd_val[g] = sec_q[g];
					FRLAC_SEL_RST: rd_val[g] = rst_q[g]
						| {7'h00, soft_busy[g]};
					FRLAC_SEL_ALARM: rd_val[g] = alarm_q[g];
					FRLAC_SEL_STATUS: rd_val[g] = {3'h0, send_japan_alarm[g],
						send_remote_alarm[g], sec_loop_line[g],
						sec_loop_sys[g], framer_rst[g]};
					default: rd_val[g] = 8'h00;
				endcase
			end
		end
	endgenerate

	// ==========================================================
	// read data, present only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst || !reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rd_val[0] | rd_val[1]; // unmapped reads give zero
		end
	end

endmodule : frlac_ctrl

`default_nettype wire

// *** verification/frlac_ctrl_props.sv ***
// assertions on framer A controls
`timescale 1ns/1ps
`default_nettype none

module frlac_ctrl_props #(
	parameter int NF = 2
) (
	// clock, reset and register port
	input wire logic                core_clk,
	input wire logic                sys_rst,
	input wire logic [11:0]         reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	// framer side inputs
	input wire logic [NF-1:0]       rx_framer_line_clock,
	input wire logic [NF-1:0]       cept_mode,
	input wire logic [NF-1:0][2:0]  primary_loop_code,
	input wire logic [NF-1:0][4:0]  primary_slot_number,
	input wire logic [NF-1:0]       sys_frame_sync,
	// control outputs
	input wire logic [NF-1:0]       framer_rst,
	input wire logic [NF-1:0]       force_realign,
	input wire logic [NF-1:0]       sec_loop_sys,
	input wire logic [NF-1:0]       sec_loop_line,
	input wire logic [NF-1:0][4:0]  secondary_slot_number,
	input wire logic [NF-1:0]       board_loop_active,
	input wire logic [NF-1:0]       line_ais_send,
	input wire logic [NF-1:0]       tx_transparent,
	input wire logic [NF-1:0]       rx_transparent,
	input wire logic [NF-1:0]       rx_align_inhibit,
	input wire logic [NF-1:0]       tx_ts0_from_sys,
	input wire logic [NF-1:0]       tx_frame_sync,
	input wire logic [NF-1:0]       send_remote_alarm,
	input wire logic [NF-1:0]       send_a_bit
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// helpers
	logic rst_wr;
	logic al_wr;
	logic [2:0] lc_cnt_q;
	assign rst_wr = reg_wr && reg_addr == frlac_pkg::RST_TRN_OFS_A;
	assign al_wr  = reg_wr && reg_addr == frlac_pkg::ALARM_OFS_A;
	// soft reset line clocks; idles at 7
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			lc_cnt_q <= 3'h7;
		else if (rst_wr && reg_wdata[0] && !framer_rst[0])
			lc_cnt_q <= 3'h0;
		else if (framer_rst[0] && rx_framer_line_clock[0] && lc_cnt_q != 3'h7)
			lc_cnt_q <= lc_cnt_q + 3'h1;
	end

	// ==========================================================
	// sequences
	sequence s_rearm;
		rst_wr && !reg_wdata[2] && !reg_wdata[1] && !reg_wdata[0] && !framer_rst[0];
	endsequence
	sequence s_fire;
		rst_wr && reg_wdata[2] && !reg_wdata[1] && !reg_wdata[0];
	endsequence

	// ==========================================================
	// properties
	a_realign_one_shot: assert property (s_rearm ##1 s_fire |-> ##2 force_realign[0] ##1 !force_realign[0])
		else $error("bad realign");
	a_realign_cause: assert property (force_realign[0] |-> $past(rst_wr, 2) && $past(reg_wdata[2], 2))
		else $error("stray realign");
	a_sec_codes_apart: assert property (!(sec_loop_sys[0] && sec_loop_line[0]))
		else $error("both loops");
	a_sec_primary_block: assert property ((sec_loop_sys[0] || sec_loop_line[0]) && $stable(primary_slot_number[0])
		|-> !($past(primary_loop_code[0]) inside {3'h1, 3'h2, 3'h6, 3'h7})
		&& primary_slot_number[0] != secondary_slot_number[0])
		else $error("loop blocked");
	a_board_sends_ais: assert property (board_loop_active[0] |-> line_ais_send[0]
		&& $past(primary_loop_code[0]) == frlac_pkg::PRI_BOARD_LOOP)
		else $error("board loop");
	a_soft_reset_hold: assert property ($fell(framer_rst[0]) |-> lc_cnt_q >= 3'h4)
		else $error("short reset");
	a_manual_alarm_out: assert property (al_wr && reg_wdata[7] && !framer_rst[0] ##1 !rst_wr
		|-> ##1 send_remote_alarm[0])
		else $error("no alarm");
	a_abit_cept_only: assert property (send_a_bit[0] |-> $past(cept_mode[0]))
		else $error("a bit ds1");
	a_sync_no_invent: assert property (tx_frame_sync[0] |-> $past(sys_frame_sync[0]))
		else $error("stray sync");
	a_rx_needs_tx: assert property (rx_transparent[0] |-> tx_transparent[0] && rx_align_inhibit[0])
		else $error("rx alone");
	a_ts0_cept_only: assert property (tx_ts0_from_sys[0] |-> $past(cept_mode[0]) && tx_transparent[0])
		else $error("bad slot 0");
endmodule : frlac_ctrl_props

bind frlac_ctrl frlac_ctrl_props #(.NF(NF)) props_u (.*);

`default_nettype wire

// *** verification/frlac_far_model.sv ***
// far side model: line clock, system sync, framer flags
`timescale 1ns/1ps
`default_nettype none

module frlac_far_model #(
	parameter int NF = 2
) (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	// flag commands from the bench, bit order as the alarm enables
	input  wire logic [NF-1:0][5:0]  cond,
	// timing
	output logic      [NF-1:0]       rx_framer_line_clock,
	output logic      [NF-1:0]       sys_frame_sync,
	// receive framer conditions
	output logic      [NF-1:0]       rx_align_loss_flag,
	output logic      [NF-1:0]       rx_sig_mf_loss_flag,
	output logic      [NF-1:0]       rx_crc_mf_loss_flag,
	output logic      [NF-1:0]       rx_mf_timer_expired,
	output logic      [NF-1:0]       rx_spare_pattern_8,
	output logic      [NF-1:0]       rx_spare_pattern_c
);
	logic [3:0] div_q;
	// ==========================================================
	// line clock every third cycle; sync every 16
	always_ff @(posedge core_clk) begin
		div_q <= sys_rst ? 4'h0 : div_q + 4'h1;
		rx_framer_line_clock <= {div_q % 3 == 1, div_q % 3 == 0};
		sys_frame_sync <= {NF{div_q == 4'h0}};
	end
	// flags one cycle late
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NF; i++) begin
			{rx_spare_pattern_c[i], rx_spare_pattern_8[i], rx_mf_timer_expired[i],
				rx_crc_mf_loss_flag[i], rx_sig_mf_loss_flag[i], rx_align_loss_flag[i]} <= cond[i];
		end
	end
endmodule : frlac_far_model

`default_nettype wire

// *** verification/frlac_ctrl_tb.sv ***
// bench of the loopback reset alarm block
`timescale 1ns/1ps
`default_nettype none

module frlac_ctrl_tb;
	localparam int NF = frlac_pkg::NUM_FRAMERS;
	logic core_clk, sys_rst, reg_wr, reg_rd;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [NF-1:0] rx_framer_line_clock, cept_mode, sys_frame_sync, rx_align_loss_flag;
	logic [NF-1:0] rx_sig_mf_loss_flag, rx_crc_mf_loss_flag, rx_mf_timer_expired;
	logic [NF-1:0] rx_spare_pattern_8, rx_spare_pattern_c, framer_rst, datalink_param_reset;
	logic [NF-1:0] force_realign, sec_loop_sys, sec_loop_line, board_loop_active, line_ais_send;
	logic [NF-1:0] tx_transparent, rx_transparent, rx_align_inhibit, tx_fbit_from_sys;
	logic [NF-1:0] rx_fbit_to_sys, tx_ts0_from_sys, rx_ts0_to_sys, tx_frame_sync;
	logic [NF-1:0] send_remote_alarm, send_a_bit, send_japan_alarm;
	logic [NF-1:0][2:0] primary_loop_code;
	logic [NF-1:0][4:0] primary_slot_number, secondary_slot_number;
	logic [NF-1:0][5:0] cond;
	logic [7:0] ex;
	int n_fail, n_checks, cyc, n;
	localparam logic [11:0] SA = frlac_pkg::SEC_LOOP_OFS_A, RA = frlac_pkg::RST_TRN_OFS_A;
	localparam logic [11:0] AA = frlac_pkg::ALARM_OFS_A;
	// places that read zero after reset
	logic [11:0] ra0 [6] = '{SA, RA, AA, frlac_pkg::SEC_LOOP_OFS_B,
		frlac_pkg::RST_TRN_OFS_B, frlac_pkg::ALARM_OFS_B};

	frlac_ctrl #(.NF(NF)) dut_u (.*);
	frlac_far_model #(.NF(NF)) far_u (.*);

	// ==========================================================
	// clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ==========================================================
	// bus and compare tasks
	task chk(input logic [7:0] got, input logic [7:0] exp);
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
		n_checks++;
	endtask : chk
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge core_clk) reg_wr <= 1'b0;
	endtask : wr
	// back-to-back writes; strobe held high between them
	task wr2(input logic [11:0] a, input logic [7:0] d1, input logic [7:0] d2);
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d1};
		@(posedge core_clk) reg_wdata <= d2;
		@(posedge core_clk) reg_wr <= 1'b0;
	endtask : wr2
	task rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	task settle;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : settle
	task automatic cnt(ref logic [NF-1:0] s, input int len, output int k);
		k = 0;
		repeat (len) begin
			@(posedge core_clk);
			#1 k += int'(s[0]);
		end
	endtask : cnt
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// test sequence
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, cond} = '0;
		{cept_mode, primary_loop_code, primary_slot_number} = '0;
		sys_rst = 1'b1;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		// reset values, unmapped address ignored
		foreach (ra0[i]) rd(ra0[i], 8'h00);
		wr(12'h0600, 8'hff);
		rd(12'h0600, 8'h00);
		$display("test reset_values done");
		// loop codes, then blocking primary modes
		for (int c = 0; c < 4; c++) begin
			ex = {1'b0, 2'(c), 5'h15};
			wr(SA, ex);
			rd(SA, ex);
			chk({sec_loop_line[0], sec_loop_sys[0], secondary_slot_number[0]}, {1'b0, ex[6:0]} & {1'b0, c != 3, c != 3, 5'h1f});
		end
		wr(SA, 8'h35);
		@(posedge core_clk) primary_slot_number <= {NF{5'h15}};
		settle();
		chk({7'h0, sec_loop_sys[0]}, 8'h00);
		@(posedge core_clk) primary_slot_number <= '0;
		for (int p = 0; p < 8; p++) begin
			@(posedge core_clk) primary_loop_code <= {NF{3'(p)}};
			settle();
			ex = {5'h0, p == 2, p == 2, !(p inside {1, 2, 6, 7})};
			chk({5'h0, board_loop_active[0], line_ais_send[0], sec_loop_sys[0]}, ex);
		end
		@(posedge core_clk) primary_loop_code <= '0;
		$display("test secondary_loop done");
		// soft reset
		wr(AA, 8'h80);
		wr(RA, 8'h01);
		rd(RA, 8'h01);
		for (int k = 0; k < 100 && framer_rst[0] !== 1'b0; k++) @(posedge core_clk);
		rd(RA, 8'h00);
		rd(SA, 8'h00);
		rd(AA, 8'h00);
		$display("test soft_reset done");
		// restart
		wr(SA, 8'h25);
		wr(RA, 8'h02);
		repeat (20) @(posedge core_clk);
		#1 chk({6'h0, framer_rst[0], datalink_param_reset[0]}, 8'h03);
		rd(SA, 8'h25);
		rd(frlac_pkg::STATUS_OFS_A, 8'h03);
		wr(RA, 8'h00);
		settle();
		chk({7'h0, framer_rst[0]}, 8'h00);
		$display("test restart done");
		// reframe edge
		wr2(RA, 8'h00, 8'h04);
		cnt(force_realign, 8, n);
		chk(8'(n), 8'h01);
		wr(RA, 8'h04);
		cnt(force_realign, 8, n);
		chk(8'(n), 8'h00);
		$display("test reframe done");
		// transparent modes; datalink select kept zero
		for (int c = 0; c < 2; c++) begin
			@(posedge core_clk) cept_mode <= {NF{c[0]}};
			for (int b = 0; b < 2; b++) begin
				wr(RA, b ? 8'h08 : 8'h10);
				settle();
				ex = {1'b0, 1'b1, b[0], b[0], !c[0], b[0] && !c[0], c[0], b[0] && c[0]};
				chk({1'b0, tx_transparent[0], rx_transparent[0], rx_align_inhibit[0], tx_fbit_from_sys[0],
					rx_fbit_to_sys[0], tx_ts0_from_sys[0], rx_ts0_to_sys[0]}, ex);
			end
		end
		$display("test transparent done");
		// sync mask
		wr(RA, 8'h20);
		cnt(tx_frame_sync, 40, n);
		chk(8'(n), 8'h00);
		wr(RA, 8'h00);
		cnt(tx_frame_sync, 40, n);
		chk({7'h0, n >= 2}, 8'h01);
		$display("test sync_mask done");
		// each alarm enable vs causes
		for (int b = 0; b < 8; b++) begin
			wr(AA, 8'h01 << b);
			for (int s = 0; s < 3; s++) begin
				@(posedge core_clk) cond <= {NF{s == 0 ? ~(6'h01 << b) : s == 1 ? 6'h01 << b : 6'h00}};
				settle();
				ex = (b > 5 || s == 1) ? {5'h0, b != 6, b != 6, b == 6} : 8'h00;
				chk({5'h0, send_remote_alarm[0], send_a_bit[0], send_japan_alarm[0]}, ex);
			end
		end
		@(posedge core_clk) cept_mode <= '0;
		wr(AA, 8'h02);
		@(posedge core_clk) cond <= {NF{6'h02}};
		settle();
		chk({7'h0, send_a_bit[0]}, 8'h00);
		$display("test alarms done");
		report_and_stop();
	end
endmodule : frlac_ctrl_tb

`default_nettype wire
